// ===== pbw_defs.svh
// Register offsets, field positions, reset values and timing figures of the
// power button and wake sequencer. Assumes inclusion by bare name.
`ifndef PBW_DEFS_SVH
`define PBW_DEFS_SVH

// Standby clock rate in hertz.
`define PBW_CLK_HZ 25000000

// Register byte offsets on the APB bus.
`define PBW_OFF_CTRL 12'h000
`define PBW_OFF_WAKE_EN 12'h004
`define PBW_OFF_STATUS 12'h008
`define PBW_OFF_WAKE_CAUSE 12'h00C

// Control register fields.
`define PBW_CTRL_ACPI_MODE 0
`define PBW_CTRL_OS_PRESENT 1
`define PBW_CTRL_SLEEP_BTN_EN 2
`define PBW_CTRL_SECOND_COM_PORT_EMP 3
`define PBW_CTRL_W 4
`define PBW_CTRL_RESET 4'h4

// Wake source bit positions, shared by the enable and cause registers.
`define PBW_SRC_RI_A 0
`define PBW_SRC_RI_B 1
`define PBW_SRC_PME 2
`define PBW_SRC_RTC 3
`define PBW_SRC_KBD 4
`define PBW_SRC_MOUSE 5
`define PBW_SRC_USB 6
`define PBW_SRC_PWR_BTN 7
`define PBW_SRC_W 8
`define PBW_WAKE_EN_RESET 8'h7F

// Status register fields.
`define PBW_STAT_CHIPSET_LSB 0
`define PBW_STAT_SEQ_LSB 2
`define PBW_STAT_SUPPLY_ON 5
`define PBW_STAT_POWER_GOOD 6

// Times in milliseconds.
`define PBW_OFF_TIMEOUT_MS 4000
`define PBW_SUPPLY_SETTLE_MS 100
`define PBW_RESET_HOLD_MS 1

`endif

// ===== pbw_pkg.sv
// Types shared by the power button and wake sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package pbw_pkg;

  // Power state reported by the chipset.
  typedef enum logic [1:0] {
    PBW_S0 = 2'b00,
    PBW_S1 = 2'b01,
    PBW_S4 = 2'b10,
    PBW_S5 = 2'b11
  } pbw_pstate_t;

  // Sequencer states.
  typedef enum logic [2:0] {
    PBW_SEQ_OFF = 3'b000,
    PBW_SEQ_PWRUP = 3'b001,
    PBW_SEQ_RESET = 3'b010,
    PBW_SEQ_ON = 3'b011,
    PBW_SEQ_OFFWAIT = 3'b100
  } pbw_seq_t;

endpackage : pbw_pkg

// ===== pbw_sync.sv
// Three-stage pin synchroniser with a settled level and a rising-edge pulse.
// Assumes asynchronous pin inputs and a free-running standby clock.
`timescale 1ns/1ps
module pbw_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  // Synchroniser stages; stage one feeds only stage two.
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // One chain per bit, the level moves only when stages two and three agree.
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        stage1[i] <= 1'b0;
        stage2[i] <= 1'b0;
        stage3[i] <= 1'b0;
        level[i] <= 1'b0;
        rise[i] <= 1'b0;
      end else if (ce) begin
        stage1[i] <= d_in[i];
        stage2[i] <= stage1[i];
        stage3[i] <= stage2[i];
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
        // One pulse per settled low-to-high change.
        rise[i] <= (stage2[i] == stage3[i]) && stage3[i] && !level[i];
      end
    end
  end

endmodule : pbw_sync

// ===== pbw_seq.sv
// Power button and wake sequencer of the standby management controller.
// Assumes APB from software, asynchronous button and wake pins, and a
// chipset that reports its power state on two pins.
//
// Functional notes
// - Power button always forwarded as chipset request.
// - Reset button always relayed as reset request.
// - NMI button raises NMI toward processors.
// - Enabled wake while off runs power-up.
// - Chipset off state drops supply power-on once system reset is released.
// - Unserviced power-off removes power after timeout.
// - Only working, standby, disk, soft-off states.
// - Reset clears the ACPI mode enable.
// - Power button wakes from every sleep state.
// - First port ring wakes standby, disk, legacy.
// - Second port ring off when used for EMP.
// - Card PME wakes standby, disk, legacy.
// - RTC: standby if enabled, disk always.
// - PS/2 activity wakes standby only.
// - USB activity wakes standby only.
// - Sleep button needs OS, raises sleep SCI.
// - Sleep button while sleeping wakes, raises SCI.
// - Disabled sleep button presses are ignored.
`timescale 1ns/1ps
`include "pbw_defs.svh"
module pbw_seq #(
  parameter int unsigned OFF_TIMEOUT_CYC = `PBW_OFF_TIMEOUT_MS * (`PBW_CLK_HZ / 1000),
  parameter int unsigned SETTLE_CYC = `PBW_SUPPLY_SETTLE_MS * (`PBW_CLK_HZ / 1000),
  parameter int unsigned RESET_HOLD_CYC = `PBW_RESET_HOLD_MS * (`PBW_CLK_HZ / 1000),
  parameter int CNT_W = 27
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Front panel buttons, active high after the board inverters.
  input wire logic power_button,
  input wire logic sleep_button,
  input wire logic reset_button,
  input wire logic nmi_button,
  // Wake sources.
  input wire logic ring_a,
  input wire logic ring_b,
  input wire logic pci_pme,
  input wire logic rtc_alarm,
  input wire logic ps2_kbd,
  input wire logic ps2_mouse,
  input wire logic usb_wake,
  // Chipset power state pins.
  input wire pbw_pkg::pbw_pstate_t chipset_state,
  // Toward chipset, processors and supply.
  output logic chipset_pwr_btn_req,
  output logic chipset_reset_req,
  output logic nmi_out,
  output logic chipset_wake,
  output logic sci_sleep_req,
  output logic sci_on_req,
  output logic supply_power_on,
  output logic power_good,
  output logic sys_reset_n
);
  import pbw_pkg::*;

  // Index of each input inside the synchroniser vector.
  localparam int IN_PWR = 0;
  localparam int IN_SLP = 1;
  localparam int IN_RST = 2;
  localparam int IN_NMI = 3;
  localparam int IN_RIA = 4;
  localparam int IN_RIB = 5;
  localparam int IN_PME = 6;
  localparam int IN_RTC = 7;
  localparam int IN_KBD = 8;
  localparam int IN_MOU = 9;
  localparam int IN_USB = 10;
  localparam int IN_CS0 = 11;
  localparam int IN_W = 13;

  logic [IN_W-1:0] pins; // Raw pin vector.
  logic [IN_W-1:0] lvl; // Settled levels.
  logic [IN_W-1:0] edg; // One-cycle press pulses.
  pbw_pstate_t cstate; // Settled chipset power state.
  pbw_pstate_t cs_prev; // Last state word; the two bits cross apart, so the word moves on two equal samples.

  logic [`PBW_CTRL_W-1:0] ctrl; // Control register.
  logic [`PBW_SRC_W-1:0] wake_en; // Wake enable register.
  logic [`PBW_SRC_W-1:0] wake_cause; // Sticky wake cause register.
  pbw_seq_t seq; // Sequencer state.
  pbw_seq_t next_seq; // Next sequencer state.
  logic [CNT_W-1:0] timer; // Shared sequencer timer.

  logic acpi_mode; // ACPI mode is on.
  logic os_present; // An operating system is running.
  logic [`PBW_SRC_W-1:0] src; // Wake source pulses by cause bit.
  logic [`PBW_SRC_W-1:0] s1_ok; // Sources allowed from standby.
  logic [`PBW_SRC_W-1:0] s4_ok; // Sources allowed from disk or soft-off.
  logic [`PBW_SRC_W-1:0] leg_ok; // Sources allowed in legacy mode.
  logic [`PBW_SRC_W-1:0] allowed; // Gate for the present state and mode.
  logic [`PBW_SRC_W-1:0] hit; // Wake sources that count now.
  logic wake; // Any wake now.
  logic sleeping; // Chipset reports standby.
  logic chip_off; // Chipset reports disk or soft-off.
  logic sleep_press; // Sleep press that may act.
  logic setup; // APB setup phase.
  logic access; // APB access phase.
  logic wr; // Write that takes effect now.
  logic mapped; // Address names a register.
  logic [CNT_W-1:0] off_last; // Last count of the power-off timeout.
  logic [CNT_W-1:0] settle_last; // Last count of the supply settle time.
  logic [CNT_W-1:0] hold_last; // Last count of the reset hold time.

  assign off_last = CNT_W'(OFF_TIMEOUT_CYC - 1);
  assign settle_last = CNT_W'(SETTLE_CYC - 1);
  assign hold_last = CNT_W'(RESET_HOLD_CYC - 1);

  assign pins = {chipset_state, usb_wake, ps2_mouse, ps2_kbd, rtc_alarm, pci_pme, ring_b, ring_a,
                 nmi_button, reset_button, sleep_button, power_button};

  // Synchroniser for every pin input.
  pbw_sync #(
    .WIDTH(IN_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d_in(pins),
    .level(lvl),
    .rise(edg)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_prev <= PBW_S0;
      cstate <= PBW_S0;
    end else if (ce) begin
      cs_prev <= pbw_pstate_t'(lvl[IN_CS0+1:IN_CS0]);
      cstate <= (cs_prev == pbw_pstate_t'(lvl[IN_CS0+1:IN_CS0])) ? cs_prev : cstate;
    end
  end
  assign sleeping = (cstate == PBW_S1);
  assign chip_off = (cstate == PBW_S4) || (cstate == PBW_S5);

  assign acpi_mode = ctrl[`PBW_CTRL_ACPI_MODE];
  assign os_present = ctrl[`PBW_CTRL_OS_PRESENT];

  // Wake source pulses in cause-bit order.
  assign src = {edg[IN_PWR], edg[IN_USB], edg[IN_MOU], edg[IN_KBD], edg[IN_RTC], edg[IN_PME],
                edg[IN_RIB], edg[IN_RIA]};

  // Builds the gate of each wake source for standby, disk and legacy.
  always_comb begin
    s1_ok = wake_en;
    s4_ok = '0;
    leg_ok = '0;
    s1_ok[`PBW_SRC_PWR_BTN] = 1'b1;
    s4_ok[`PBW_SRC_PWR_BTN] = 1'b1;
    leg_ok[`PBW_SRC_PWR_BTN] = 1'b1;
    s4_ok[`PBW_SRC_RI_A] = wake_en[`PBW_SRC_RI_A];
    leg_ok[`PBW_SRC_RI_A] = wake_en[`PBW_SRC_RI_A];
    s1_ok[`PBW_SRC_RI_B] = wake_en[`PBW_SRC_RI_B] && !ctrl[`PBW_CTRL_SECOND_COM_PORT_EMP];
    s4_ok[`PBW_SRC_RI_B] = s1_ok[`PBW_SRC_RI_B];
    leg_ok[`PBW_SRC_RI_B] = s1_ok[`PBW_SRC_RI_B];
    s4_ok[`PBW_SRC_PME] = wake_en[`PBW_SRC_PME];
    leg_ok[`PBW_SRC_PME] = wake_en[`PBW_SRC_PME];
    s4_ok[`PBW_SRC_RTC] = 1'b1;
    // PS/2 and USB standby only: left clear in disk and legacy gates.
  end

  // Picks the gate for the chipset state and mode.
  always_comb begin
    if (!acpi_mode) begin
      allowed = leg_ok;
    end else if (sleeping) begin
      allowed = s1_ok;
    end else begin
      allowed = s4_ok;
    end
  end

  // Only a system that is asleep or off can be woken.
  assign hit = (sleeping || seq == PBW_SEQ_OFF) ? (src & allowed) : '0;
  assign wake = |hit;

  assign sleep_press = edg[IN_SLP] && ctrl[`PBW_CTRL_SLEEP_BTN_EN];

  // Sequencer next state.
  always_comb begin
    next_seq = seq;
    unique case (seq)
      PBW_SEQ_OFF: begin
        if (wake) begin
          next_seq = PBW_SEQ_PWRUP;
        end
      end
      PBW_SEQ_PWRUP: begin
        if (timer == settle_last) begin
          next_seq = PBW_SEQ_RESET;
        end
      end
      PBW_SEQ_RESET: begin
        if (timer == hold_last) begin
          next_seq = PBW_SEQ_ON;
        end
      end
      PBW_SEQ_ON: begin
        if (chip_off) begin
          next_seq = PBW_SEQ_OFF;
        end else if (edg[IN_PWR] && !os_present && !sleeping) begin
          next_seq = PBW_SEQ_OFFWAIT;
        end
      end
      PBW_SEQ_OFFWAIT: begin
        if (chip_off || timer == off_last) begin
          next_seq = PBW_SEQ_OFF;
        end
      end
      default: begin
        next_seq = PBW_SEQ_OFF;
      end
    endcase
  end

  // Sequencer state register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq <= PBW_SEQ_OFF;
    end else if (ce) begin
      seq <= next_seq;
    end
  end

  // Timer restarts on every state change and counts within a state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer <= '0;
    end else if (ce) begin
      if (next_seq != seq) begin
        timer <= '0;
      end else begin
        timer <= timer + CNT_W'(1);
      end
    end
  end

  // Supply and reset outputs follow the sequencer state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_power_on <= 1'b0;
      power_good <= 1'b0;
      sys_reset_n <= 1'b0;
    end else if (ce) begin
      supply_power_on <= (next_seq != PBW_SEQ_OFF);
      power_good <= (next_seq == PBW_SEQ_RESET) || (next_seq == PBW_SEQ_ON) ||
                    (next_seq == PBW_SEQ_OFFWAIT);
      sys_reset_n <= (next_seq == PBW_SEQ_ON) || (next_seq == PBW_SEQ_OFFWAIT);
    end
  end

  // Button relays and SCI requests, each a one-cycle pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chipset_pwr_btn_req <= 1'b0;
      chipset_reset_req <= 1'b0;
      nmi_out <= 1'b0;
      chipset_wake <= 1'b0;
      sci_sleep_req <= 1'b0;
      sci_on_req <= 1'b0;
    end else if (ce) begin
      chipset_pwr_btn_req <= edg[IN_PWR];
      chipset_reset_req <= edg[IN_RST];
      nmi_out <= edg[IN_NMI];
      chipset_wake <= (wake && sleeping) || (sleep_press && os_present && sleeping);
      sci_sleep_req <= sleep_press && os_present && cstate == PBW_S0 && seq == PBW_SEQ_ON;
      sci_on_req <= sleep_press && os_present && sleeping;
    end
  end

  // APB decode; every access completes without wait states.
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign mapped = (paddr == `PBW_OFF_CTRL) || (paddr == `PBW_OFF_WAKE_EN) ||
                  (paddr == `PBW_OFF_STATUS) || (paddr == `PBW_OFF_WAKE_CAUSE);
  assign wr = access && pwrite && mapped && ce;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // Control register; the ACPI mode bit starts cleared at every reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `PBW_CTRL_RESET;
    end else if (wr && paddr == `PBW_OFF_CTRL) begin
      ctrl <= pwdata[`PBW_CTRL_W-1:0];
    end
  end

  // Wake enable register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_en <= `PBW_WAKE_EN_RESET;
    end else if (wr && paddr == `PBW_OFF_WAKE_EN) begin
      wake_en <= pwdata[`PBW_SRC_W-1:0];
    end
  end

  // Sticky wake causes; write one clears, a new wake in that cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cause <= '0;
    end else if (ce) begin
      if (wr && paddr == `PBW_OFF_WAKE_CAUSE) begin
        wake_cause <= (wake_cause & ~pwdata[`PBW_SRC_W-1:0]) | hit;
      end else begin
        wake_cause <= wake_cause | hit;
      end
    end
  end

  // Read data is captured in the setup phase and held for the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (ce && setup) begin
      prdata <= '0;
      if (paddr == `PBW_OFF_CTRL) begin
        prdata[`PBW_CTRL_W-1:0] <= ctrl;
      end else if (paddr == `PBW_OFF_WAKE_EN) begin
        prdata[`PBW_SRC_W-1:0] <= wake_en;
      end else if (paddr == `PBW_OFF_STATUS) begin
        prdata[`PBW_STAT_CHIPSET_LSB+1:`PBW_STAT_CHIPSET_LSB] <= cstate;
        prdata[`PBW_STAT_SEQ_LSB+2:`PBW_STAT_SEQ_LSB] <= seq;
        prdata[`PBW_STAT_SUPPLY_ON] <= supply_power_on;
        prdata[`PBW_STAT_POWER_GOOD] <= power_good;
      end else if (paddr == `PBW_OFF_WAKE_CAUSE) begin
        prdata[`PBW_SRC_W-1:0] <= wake_cause;
      end
    end
  end

endmodule : pbw_seq

// ===== pbw_seq_checker.sv
// Concurrent checks on the sequencer's ports.
// Assumes bind to pbw_seq built with SETTLE_CYC 10 and RESET_HOLD_CYC 5.
`timescale 1ns/1ps
module pbw_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic power_button,
  input wire logic reset_button,
  input wire logic nmi_button,
  input wire pbw_pkg::pbw_pstate_t chipset_state,
  input wire logic chipset_pwr_btn_req,
  input wire logic chipset_reset_req,
  input wire logic nmi_out,
  input wire logic supply_power_on,
  input wire logic power_good,
  input wire logic sys_reset_n
);
  import pbw_pkg::*;
  // Every check runs on the standby clock and rests in reset.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_pwr_forward: assert property ($rose(power_button) |-> ##[2:8] chipset_pwr_btn_req)
    else $error("power press not forwarded");
  chk_reset_relay: assert property ($rose(reset_button) |-> ##[2:8] chipset_reset_req)
    else $error("reset press not relayed");
  chk_nmi_relay: assert property ($rose(nmi_button) |-> ##[2:8] nmi_out)
    else $error("nmi press not relayed");
  chk_pg_order: assert property (power_good |-> supply_power_on)
    else $error("power good without supply");
  chk_rst_order: assert property (sys_reset_n |-> power_good)
    else $error("reset released without power good");
  chk_supply_settle: assert property ($rose(supply_power_on) |-> !power_good [*8])
    else $error("power good too early");
  chk_reset_hold: assert property ($rose(power_good) |-> !sys_reset_n [*4] ##[1:4] sys_reset_n)
    else $error("reset hold length wrong");
  chk_off_drop: assert property ((sys_reset_n && chipset_state[1]) [*6] |-> ##[0:3] !supply_power_on)
    else $error("supply kept on in chipset off");
  chk_reset_once: assert property (chipset_reset_req |=> !chipset_reset_req)
    else $error("reset request longer than one cycle");
  chk_nmi_once: assert property (nmi_out |=> !nmi_out)
    else $error("nmi longer than one cycle");
  // Main scenarios seen.
  cov_power_up: cover property ($rose(sys_reset_n));
  cov_power_down: cover property ($fell(supply_power_on));
  cov_reset_relay: cover property (chipset_reset_req);
endmodule : pbw_checker

bind pbw_seq pbw_checker pbw_checker_i (.pclk, .presetn, .power_button, .reset_button, .nmi_button,
  .chipset_state, .chipset_pwr_btn_req, .chipset_reset_req, .nmi_out, .supply_power_on,
  .power_good, .sys_reset_n);

// ===== pbw_chipset_model.sv
// Behavioural chipset power state machine beside the sequencer.
// Assumes the bench commands sleep and off as software would.
`timescale 1ns/1ps
module pbw_chipset_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic supply_power_on,
  input wire logic chipset_wake,
  input wire logic go_sleep,
  input wire logic go_off,
  input wire logic [1:0] lat,
  output pbw_pkg::pbw_pstate_t chipset_state
);
  import pbw_pkg::*;
  logic [2:0] wait_cnt; // Cycles left before reaching S0.
  // Walks the power states; lat makes the answer prompt or slow.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chipset_state <= PBW_S5;
      wait_cnt <= 3'h0;
    end else if (!supply_power_on || go_off) begin
      chipset_state <= PBW_S5;
      wait_cnt <= 3'h0;
    end else if (go_sleep) begin
      chipset_state <= PBW_S1;
    end else if (wait_cnt == 3'h1) begin
      chipset_state <= PBW_S0;
      wait_cnt <= 3'h0;
    end else if (wait_cnt != 3'h0) begin
      wait_cnt <= wait_cnt - 3'h1;
    end else if (chipset_state == PBW_S5 || (chipset_state == PBW_S1 && chipset_wake)) begin
      wait_cnt <= {1'b0, lat} + 3'h1;
    end
  end
endmodule : pbw_chipset_model

// ===== pbw_seq_test.sv
// Self-checking bench of the power button and wake sequencer.
// Assumes the chipset model and bound checker compile alongside.
`timescale 1ns/1ps
`include "pbw_defs.svh"
module pbw_seq_test;
  import pbw_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [10:0] pins = 11'h000; // Buttons then wake sources, low bit first.
  logic [5:0] pulses; // One bit for each relay or request pulse.
  logic [2:0] pwr; // Supply, power good, reset release.
  logic go_sleep = 1'b0;
  logic go_off = 1'b0;
  logic [1:0] lat = 2'h0;
  pbw_pstate_t chipset_state;
  logic [31:0] exp_rd[$]; // Expected read data.
  logic [5:0] exp_pl[$]; // Expected pulse patterns.
  logic exp_er[$]; // Expected error flags, one per transfer.
  logic ce = 1'b1; // Clock enable, dropped once to freeze the block.
  int err_total = 0;
  int num_checks = 0;
  // Standby clock at 25 MHz.
  always #20 pclk = ~pclk;
  pbw_seq #(.OFF_TIMEOUT_CYC(50), .SETTLE_CYC(10), .RESET_HOLD_CYC(5)) pbw_seq_i (.pclk, .presetn,
    .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .power_button(pins[0]), .sleep_button(pins[1]), .reset_button(pins[2]), .nmi_button(pins[3]),
    .ring_a(pins[4]), .ring_b(pins[5]), .pci_pme(pins[6]), .rtc_alarm(pins[7]), .ps2_kbd(pins[8]),
    .ps2_mouse(pins[9]), .usb_wake(pins[10]), .chipset_state, .chipset_pwr_btn_req(pulses[0]),
    .chipset_reset_req(pulses[1]), .nmi_out(pulses[2]), .chipset_wake(pulses[3]),
    .sci_sleep_req(pulses[4]), .sci_on_req(pulses[5]), .supply_power_on(pwr[2]),
    .power_good(pwr[1]), .sys_reset_n(pwr[0]));
  pbw_chipset_model pbw_chipset_model_i (.pclk, .presetn, .supply_power_on(pwr[2]),
    .chipset_wake(pulses[3]), .go_sleep, .go_off, .lat, .chipset_state);
  // Counts a comparison and reports a mismatch.
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check
  // Takes the oldest note whenever a read or a pulse shows.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      check(prdata, exp_rd.size() ? exp_rd.pop_front() : 32'hFFFFFFFF);
    end
    if (psel && penable && pready) begin
      check(pslverr, exp_er.size() ? exp_er.pop_front() : 1'b1);
    end
    if (pulses !== 6'h00) begin
      check(pulses, exp_pl.size() ? exp_pl.pop_front() : 6'h00);
    end
  end
  // One APB transfer and an idle cycle; a read notes d as its expected data.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    if (!wr) exp_rd.push_back(d);
    exp_er.push_back(a > `PBW_OFF_WAKE_CAUSE);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Presses pin b for a random time and notes the pulses it should give.
  task automatic press(input int b, input logic [5:0] e);
    if (e != 6'h00) exp_pl.push_back(e);
    pins[b] <= 1'b1;
    repeat (3 + $urandom_range(3)) @(posedge pclk);
    pins[b] <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask : press
  // Waits, bounded, for the power outputs to reach w.
  task automatic wait_st(input logic [2:0] w);
    int n;
    n = 0;
    while (pwr !== w && n < 300) begin
      @(posedge pclk);
      n++;
    end
    check(pwr, w);
  endtask : wait_st
  // Puts the chipset into standby with a random wake latency.
  task automatic sleep_now();
    lat <= 2'($urandom_range(3));
    go_sleep <= 1'b1;
    @(posedge pclk);
    go_sleep <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask : sleep_now
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask : do_reset
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    check(exp_pl.size() + exp_rd.size() + exp_er.size(), 0);
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    $display("wrong value at %0t: run timed out", $time);
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h31953698));
    do_reset();
    apb(1'b0, `PBW_OFF_CTRL, 32'h4);
    apb(1'b0, `PBW_OFF_WAKE_EN, 32'h7F);
    apb(1'b0, `PBW_OFF_STATUS, 32'h3);
    apb(1'b0, 12'h010, 32'h0);
    press(0, 6'h01);
    wait_st(3'b111);
    apb(1'b0, `PBW_OFF_STATUS, 32'h6C);
    press(2, 6'h02);
    press(3, 6'h04);
    press(1, 6'h00);
    apb(1'b1, `PBW_OFF_CTRL, 32'h7);
    press(1, 6'h10);
    apb(1'b1, `PBW_OFF_CTRL, 32'h3);
    press(1, 6'h00);
    apb(1'b1, `PBW_OFF_CTRL, 32'h7);
    for (int s = 4; s < 11; s++) begin
      sleep_now();
      press(s, 6'h08);
    end
    apb(1'b0, `PBW_OFF_WAKE_CAUSE, 32'hFF);
    apb(1'b1, `PBW_OFF_WAKE_CAUSE, 32'hFF);
    apb(1'b0, `PBW_OFF_WAKE_CAUSE, 32'h0);
    apb(1'b1, `PBW_OFF_CTRL, 32'hF);
    sleep_now();
    press(5, 6'h00);
    press(1, 6'h28);
    do_reset();
    apb(1'b0, `PBW_OFF_CTRL, 32'h4);
    press(7, 6'h00);
    check(pwr, 3'b000);
    press(10, 6'h00);
    check(pwr, 3'b000);
    press(4, 6'h00);
    wait_st(3'b111);
    press(0, 6'h01);
    // Clock enable low freezes the timeout and blocks bus writes.
    ce <= 1'b0;
    apb(1'b1, `PBW_OFF_CTRL, 32'h7);
    repeat (40) @(posedge pclk);
    ce <= 1'b1;
    apb(1'b0, `PBW_OFF_CTRL, 32'h4);
    repeat (25) @(posedge pclk);
    check(pwr, 3'b111);
    wait_st(3'b000);
    apb(1'b1, `PBW_OFF_CTRL, 32'h1);
    press(7, 6'h00);
    wait_st(3'b111);
    go_off <= 1'b1;
    wait_st(3'b000);
    go_off <= 1'b0;
    repeat (10) @(posedge pclk);
    report_and_stop();
  end
endmodule : pbw_seq_test
